//--- design/omc_mode_ctrl.sv
// Operating mode control register with AXI4-Lite access
// Summary of operation
// RQ1: Chop field selects low, high, toggling modes
// RQ2: Chop toggles only during conversion, at boundaries
// RQ3: Force-on bit enables pump, wins over off
// RQ4: Force-off bit disables pump; resets set
// RQ5: Reference-out bit drives reference on pin0
// RQ6: External-reference bit takes pin1 as input
// RQ7: Software picks pump force by supply voltage
// RQ8: Pin0 value only when output, no reference
// RQ9: Pin1 value only when output, no ext-ref
// RQ10: Software writes reserved bits with reset values
// RQ11: Bits 7:6 read-only, return 1 and 0
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "omc_defs.svh"
module omc_mode_ctrl
#(
    parameter int AW = `OMC_AXI_AW
)
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          conv_busy,
    input  wire logic          elconv_done,
    input  wire logic          gp0_direction,
    input  wire logic          gp1_direction,
    input  wire logic          gp0_output_value,
    input  wire logic          gp1_output_value,
    input  wire logic          gp0_in,
    input  wire logic          gp1_in,
    output logic               gp0_out,
    output logic               gp0_oe_n,
    output logic               gp1_out,
    output logic               gp1_oe_n,
    output logic               gp0_ref_out_en,
    output logic               gp1_ext_ref_in_en,
    output logic               ext_ref_level,
    output logic               pump_on,
    output logic               chop_state
);
    // Parameter check
    if (AW < 8) $error("omc_mode_ctrl: address width below 8");

    // Whole block state
    typedef struct packed
    {
        logic [5:0]  mode;      // Writable bits 5:0
        logic        aw_got;    // Write address held
        logic        w_got;     // Write data held
        logic [AW-1:0] awaddr;  // Held write address
        logic [7:0]  wdata;     // Held low write byte
        logic        wstb;      // Held low byte strobe
        logic        bvalid;    // Write response pending
        logic [1:0]  bresp;     // Write response code
        logic        rvalid;    // Read data pending
        logic [31:0] rdata;     // Read data
        logic [1:0]  rresp;     // Read response code
        logic        out0;      // Pin0 output flop
        logic        oen0;      // Pin0 enable flop
        logic        out1;      // Pin1 output flop
        logic        oen1;      // Pin1 enable flop
    } omc_state_s;

    omc_state_s r;
    omc_state_s next_r;
    omc_chop_if chop_link ();
    logic [7:0] reg_view;   // Full register as read

    // Reserved bits are constant, never stored
    assign reg_view = {`OMC_RSVD_VALUE, r.mode}; // [RQ11]

    // Bus, register and pin next state
    always_comb
    begin
        next_r = r;
        // Accept address and data in any order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata[7:0];
            next_r.wstb  = s_axi_wstrb[0];
        end
        // Perform write once both halves are held
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            if (r.awaddr == AW'(`OMC_MODE_OFFSET))
            begin
                next_r.bresp = `OMC_RESP_OKAY;
                if (r.wstb)
                begin
                    // Bits 7:6 dropped on write
                    next_r.mode = r.wdata[5:0]; // [RQ11] [RQ3] [RQ4] [RQ5] [RQ6]
                end
            end
            else
            begin
                next_r.bresp = `OMC_RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready)
        begin
            next_r.bvalid = 1'b0;
        end
        // Read path
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_r.rvalid = 1'b1;
            if (s_axi_araddr == AW'(`OMC_MODE_OFFSET))
            begin
                next_r.rdata = {24'h000000, reg_view};
                next_r.rresp = `OMC_RESP_OKAY;
            end
            else
            begin
                next_r.rdata = 32'h00000000;
                next_r.rresp = `OMC_RESP_SLVERR;
            end
        end
        else if (r.rvalid && s_axi_rready)
        begin
            next_r.rvalid = 1'b0;
        end
        // Pin0 drives its value only as plain output
        next_r.out0 = gp0_output_value;
        next_r.oen0 = ~(gp0_direction && !r.mode[`OMC_REF_OUT_BIT]); // [RQ8]
        // Pin1 drives its value only as plain output
        next_r.out1 = gp1_output_value;
        next_r.oen1 = ~(gp1_direction && !r.mode[`OMC_EXT_REF_BIT]); // [RQ9]
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r      <= '0;
            r.mode <= 6'(`OMC_MODE_RESET); // [RQ1] [RQ4]
            r.oen0 <= 1'b1;
            r.oen1 <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Handshake outputs
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready  = !r.w_got && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    // Pump: force-on wins, else off when forced off
    assign pump_on = r.mode[`OMC_FORCE_ON_BIT] || !r.mode[`OMC_FORCE_OFF_BIT]; // [RQ3] [RQ4]
    assign gp0_ref_out_en    = r.mode[`OMC_REF_OUT_BIT];  // [RQ5]
    assign gp1_ext_ref_in_en = r.mode[`OMC_EXT_REF_BIT];  // [RQ6]
    // Pin1 level passed on as external reference
    assign ext_ref_level = r.mode[`OMC_EXT_REF_BIT] && gp1_in; // [RQ6]
    assign gp0_out  = r.out0;
    assign gp0_oe_n = r.oen0;
    assign gp1_out  = r.out1;
    assign gp1_oe_n = r.oen1;

    // Chop field toward sequencer
    assign chop_link.mode = omc_pkg::omc_chop_e'(r.mode[`OMC_CHOP_MSB:`OMC_CHOP_LSB]);
    assign chop_state = chop_link.state;

    // Chop sequencer
    omc_chop_seq u_chop
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .conv_busy   (conv_busy),
        .elconv_done (elconv_done),
        .chop        (chop_link.seq)
    );

    // Checks
    chk_pump_on_win: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ3]
        r.mode[`OMC_FORCE_ON_BIT] |-> pump_on)
        else $error("force-on did not win");
    chk_pump_off_force: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4]
        (r.mode[`OMC_FORCE_OFF_BIT] && !r.mode[`OMC_FORCE_ON_BIT]) |-> !pump_on)
        else $error("pump on while forced off");
    chk_rsvd_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
        s_axi_rvalid && s_axi_rresp == `OMC_RESP_OKAY |-> s_axi_rdata[7:6] == 2'h2)
        else $error("reserved bits read wrong");
    chk_gp0_release: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
        $past(r.mode[`OMC_REF_OUT_BIT]) |-> gp0_oe_n)
        else $error("pin0 driven while reference out");
    chk_gp1_release: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
        $past(r.mode[`OMC_EXT_REF_BIT]) |-> gp1_oe_n)
        else $error("pin1 driven while external reference");
    // Reference enable only moves with a performed write
    chk_ref_out_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
        $changed(gp0_ref_out_en) |-> $rose(s_axi_bvalid))
        else $error("reference output enable moved without a write");
    chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_chop_fixed: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
        (chop_link.mode == omc_pkg::OMC_CHOP_HIGH) |=> chop_state)
        else $error("chop not held high");
    cov_write_done: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
    cov_read_done: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
    cov_both_force: cover property (@(posedge aclk) r.mode[3] && r.mode[2]);
endmodule // omc_mode_ctrl
`default_nettype wire

//--- common/omc_defs.svh
// Register offsets, field positions and reset values of the mode control block
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_MODE_OFFSET   8'h70
`define OMC_AXI_AW        8
`define OMC_CHOP_MSB      5
`define OMC_CHOP_LSB      4
`define OMC_FORCE_ON_BIT  3
`define OMC_FORCE_OFF_BIT 2
`define OMC_REF_OUT_BIT   1
`define OMC_EXT_REF_BIT   0
`define OMC_RSVD_VALUE    2'h2
`define OMC_MODE_RESET    8'h84
`define OMC_RESP_OKAY     2'h0
`define OMC_RESP_SLVERR   2'h2
`endif

//--- common/omc_pkg.sv
// Types shared by the mode control block
`default_nettype none
package omc_pkg;
    typedef enum logic [1:0] {
        OMC_CHOP_LOW   = 2'h0,
        OMC_CHOP_HIGH  = 2'h1,
        OMC_CHOP_EVERY = 2'h2,
        OMC_CHOP_HALF  = 2'h3
    } omc_chop_e;
endpackage
`default_nettype wire

//--- common/omc_chop_if.sv
// Link between the register block and the chop sequencer
`timescale 1ns/10ps
`default_nettype none
interface omc_chop_if;
    omc_pkg::omc_chop_e mode;      // Selected chop behaviour
    logic               state;     // Current chop state
    modport ctrl (output mode, input state);
    modport seq  (input mode, output state);
endinterface
`default_nettype wire

//--- design/omc_chop_seq.sv
// Bandgap chop state sequencer
`timescale 1ns/10ps
`default_nettype none
module omc_chop_seq
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic conv_busy,
    input  wire logic elconv_done,
    omc_chop_if.seq   chop
);
    // Full state of the sequencer
    typedef struct packed
    {
        logic state;   // Chop level
        logic half;    // Boundary parity for half rate
    } omc_seq_s;

    omc_seq_s r;
    omc_seq_s next_r;

    // Next state from mode and conversion boundaries
    always_comb
    begin
        next_r = r;
        unique case (chop.mode)
            omc_pkg::OMC_CHOP_LOW:
            begin
                next_r.state = 1'b0; // [RQ1]
                next_r.half  = 1'b0;
            end
            omc_pkg::OMC_CHOP_HIGH:
            begin
                next_r.state = 1'b1; // [RQ1]
                next_r.half  = 1'b0;
            end
            omc_pkg::OMC_CHOP_EVERY:
            begin
                // Toggle on each boundary inside a conversion
                if (conv_busy && elconv_done)
                begin
                    next_r.state = ~r.state; // [RQ1] [RQ2]
                end
            end
            omc_pkg::OMC_CHOP_HALF:
            begin
                // Toggle on every second boundary
                if (conv_busy && elconv_done)
                begin
                    next_r.half = ~r.half;
                    if (r.half)
                    begin
                        next_r.state = ~r.state; // [RQ1] [RQ2]
                    end
                end
            end
        endcase
        if (!conv_busy)
        begin
            next_r.half = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign chop.state = r.state;

    // Toggling modes never change the state outside a conversion
    chk_chop_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
        (!conv_busy && chop.mode[1]) |=> $stable(chop.state))
        else $error("chop state moved outside a conversion");
    // Every-boundary mode toggles on each boundary inside a conversion
    chk_chop_every_tog: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
        (chop.mode == omc_pkg::OMC_CHOP_EVERY && conv_busy && elconv_done)
        |=> chop.state != $past(chop.state))
        else $error("chop did not toggle at boundary");
    cov_half_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
        chop.mode == omc_pkg::OMC_CHOP_HALF ##1 $changed(chop.state));
endmodule // omc_chop_seq
`default_nettype wire

//--- test/omc_host_model.sv
// AXI4-Lite master standing in for host software
`timescale 1ns/10ps
`default_nettype none
module omc_host_model
#(
    parameter int AW = 8
)
(
    input  wire logic          aclk,
    output logic [AW-1:0]      s_axi_awaddr,
    output logic               s_axi_awvalid,
    input  wire logic          s_axi_awready,
    output logic [31:0]        s_axi_wdata,
    output logic [3:0]         s_axi_wstrb,
    output logic               s_axi_wvalid,
    input  wire logic          s_axi_wready,
    input  wire logic [1:0]    s_axi_bresp,
    input  wire logic          s_axi_bvalid,
    output logic               s_axi_bready,
    output logic [AW-1:0]      s_axi_araddr,
    output logic               s_axi_arvalid,
    input  wire logic          s_axi_arready,
    input  wire logic [31:0]   s_axi_rdata,
    input  wire logic [1:0]    s_axi_rresp,
    input  wire logic          s_axi_rvalid,
    output logic               s_axi_rready
);
    logic to;  // Last transfer ran out of its bound
    // Quiet bus at time zero
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, to} = '0;
    end
    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        int   n;
        logic ha, hw, hb;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        hb = 1'b0;
        for (n = 0; n < 40 && !hb; n++)
        begin
            @(negedge aclk);  // Settled view of the coming edge
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hb = s_axi_bvalid & s_axi_bready;
            r  = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
        end
        to = !hb;
    endtask
    // Single read, rready held until data seen
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ha, hr;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        hr = 1'b0;
        for (n = 0; n < 40 && !hr; n++)
        begin
            @(negedge aclk);
            ha = s_axi_arvalid & s_axi_arready;
            hr = s_axi_rvalid & s_axi_rready;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
        end
        to = !hr;
    endtask
endmodule // omc_host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the mode control register block
`timescale 1ns/10ps
`default_nettype none
`include "omc_defs.svh"
module testbench;
    localparam logic [7:0] OFF = `OMC_MODE_OFFSET;  // Mode register address
    logic aclk, aresetn, conv_busy, elconv_done;     // Clock, reset, converter
    logic [7:0] s_axi_awaddr, s_axi_araddr;          // Bus addresses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;           // Bus data
    logic [3:0] s_axi_wstrb;                         // Byte strobes
    logic [1:0] s_axi_bresp, s_axi_rresp;            // Responses
    logic gp0_direction, gp1_direction, gp0_output_value, gp1_output_value;
    logic gp0_in, gp1_in, gp0_out, gp0_oe_n, gp1_out, gp1_oe_n;
    logic gp0_ref_out_en, gp1_ext_ref_in_en, ext_ref_level, pump_on, chop_state;
    int   error_cnt, total_checks;                   // Verdict counters
    omc_mode_ctrl #(.AW(8)) dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_busy, .elconv_done,
        .gp0_direction, .gp1_direction, .gp0_output_value, .gp1_output_value,
        .gp0_in, .gp1_in, .gp0_out, .gp0_oe_n, .gp1_out, .gp1_oe_n, .gp0_ref_out_en,
        .gp1_ext_ref_in_en, .ext_ref_level, .pump_on, .chop_state
    );
    omc_host_model #(.AW(8)) host
    (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    // Free-running 10 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-bit compare
    task automatic chk1(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask
    // Hung bus counts as failure
    task automatic hung();
        if (host.to)
        begin
            error_cnt++;
            close_out();
        end
    endtask
    // Register write with expected response
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, {24'h0, d}, s, r);
        hung();
        chk({30'h0, r}, {30'h0, er});
    endtask
    // Register read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        hung();
        chk(d, {24'h0, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask
    // One elementary conversion boundary, then settle
    task automatic pulse();
        @(posedge aclk);
        elconv_done <= 1'b1;
        @(posedge aclk);
        elconv_done <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
    endtask
    // Reset values at the pins and in the register
    task automatic t_reset();
        rd(OFF, `OMC_MODE_RESET, `OMC_RESP_OKAY);
        @(negedge aclk);
        chk1(pump_on, 1'b0);
        chk1(chop_state, 1'b0);
        chk({30'h0, gp0_ref_out_en, gp1_ext_ref_in_en}, 32'h0);
    endtask
    // Reserved bits, strobe-less write, unmapped place
    task automatic t_access();
        wr(OFF, 8'h7F, 4'h1, `OMC_RESP_OKAY);
        rd(OFF, 8'hBF, `OMC_RESP_OKAY);
        wr(OFF, 8'h84, 4'h0, `OMC_RESP_OKAY);
        rd(OFF, 8'hBF, `OMC_RESP_OKAY);
        wr(8'h74, 8'h84, 4'h1, `OMC_RESP_SLVERR);
        rd(8'h74, 8'h00, `OMC_RESP_SLVERR);
        rd(OFF, 8'hBF, `OMC_RESP_OKAY);
    endtask
    // Every force-on and force-off combination
    task automatic t_pump();
        for (int k = 0; k < 4; k++)
        begin
            wr(OFF, 8'h80 | 8'(k << 2), 4'h1, `OMC_RESP_OKAY);
            @(negedge aclk);
            chk1(pump_on, k[1] | ~k[0]);
        end
    endtask
    // Pin ownership over direction, value and reference enables
    task automatic t_pins();
        logic ro, ei;  // Reference-out and external-reference bits
        for (int k = 0; k < 8; k++)
        begin
            ro = k[0];
            ei = k[0] ^ k[2];
            @(posedge aclk);
            {gp0_direction, gp1_direction} <= {2{k[1]}};
            {gp0_output_value, gp1_output_value, gp1_in} <= {3{k[2]}};
            gp0_in <= ~k[2];
            wr(OFF, 8'h84 | {6'h0, ro, ei}, 4'h1, `OMC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk1(gp0_ref_out_en, ro);
            chk1(gp1_ext_ref_in_en, ei);
            chk1(gp0_oe_n, ~(k[1] & ~ro));
            chk1(gp1_oe_n, ~(k[1] & ~ei));
            if (k[1] & ~ro) chk1(gp0_out, k[2]);
            if (k[1] & ~ei) chk1(gp1_out, k[2]);
            chk1(ext_ref_level, ei & k[2]);
        end
    endtask
    // Reset in mid-run restores every field
    task automatic t_rerst();
        wr(OFF, 8'hBE, 4'h1, `OMC_RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
    endtask
    // Fixed and toggling chop modes, in and out of conversion
    task automatic t_chop();
        logic e;
        wr(OFF, 8'h94, 4'h1, `OMC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk1(chop_state, 1'b1);
        wr(OFF, 8'hA4, 4'h1, `OMC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk1(chop_state, 1'b1);
        pulse();
        chk1(chop_state, 1'b1);
        e = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            wr(OFF, m ? 8'hB4 : 8'hA4, 4'h1, `OMC_RESP_OKAY);
            @(posedge aclk);
            conv_busy <= 1'b1;
            for (int i = 1; i < 5; i++)
            begin
                pulse();
                if (m == 0 || i % 2 == 0) e = ~e;
                chk1(chop_state, e);
            end
            @(posedge aclk);
            conv_busy <= 1'b0;
        end
        wr(OFF, 8'h84, 4'h1, `OMC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk1(chop_state, 1'b0);
    endtask
    // Main sequence
    initial
    begin
        {aresetn, conv_busy, elconv_done, gp0_direction, gp1_direction} = '0;
        {gp0_output_value, gp1_output_value, gp0_in, gp1_in} = '0;
        error_cnt = 0;
        total_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_access();
        t_pump();
        t_pins();
        t_chop();
        t_rerst();
        close_out();
    end
endmodule // testbench
`default_nettype wire
